// ---- rtl/adc_serial_port.sv ----
// Serial port and conversion sequencer of a multichannel sampling converter.
//
// Function
// RQ1 - Frame sync fall: shift ten control bits
// RQ2 - Ignore serial clock until read sync rises
// RQ3 - Clear read bit counter after each read
// RQ4 - Drive result bits on serial clock rise
// RQ5 - Release data output on eleventh rise
// RQ6 - Thirteen clocks per write, keep ten
// RQ7 - Sample data input on falling edges
// RQ8 - Trigger fall: hold and start conversion
// RQ9 - Trigger level at end decides power-down
// RQ10 - Address pin plus word address bit
// RQ11 - Host sets reference select for external
// RQ12 - Read sync doubles as bus select
// RQ13 - Drop mismatched word; last owner drives
// RQ14 - Ten bit write-only word, resets zero
// RQ15 - Data output released outside read frames
`include "adc_port_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_serial_port (
    // Core clock and reset
    input  wire logic                     i_core_clk,
    input  wire logic                     i_rstn,
    // Serial link from the host
    input  wire logic                     i_serial_clk,
    input  wire logic                     i_transmit_frame_sync,
    input  wire logic                     i_receive_frame_sync,
    input  wire logic                     i_serial_din,
    output logic                          o_serial_dout,
    output logic                          o_serial_dout_oe,
    // Hardware pins
    input  wire logic                     i_conversion_trigger,
    input  wire logic                     i_package_address_pin,
    // Analogue core
    input  wire logic [`ADC_WORD_BITS-1:0] i_conv_result,
    output logic                          o_track_hold,
    output logic                          o_power_down,
    output logic                          o_partial_power_down,
    output logic                          o_external_reference_select,
    output logic      [3:0]               o_input_config
);

    import adc_port_pkg::*;

    // ======================================================================
    // Declarations
    localparam int WB = `ADC_WORD_BITS;

    // Link domain, falling edge; address pin synchroniser on rising edge
    logic                 tfs_prev_reg;
    logic [3:0]           wr_cnt_reg;
    logic [WB-1:0]        wr_shift_reg;
    ctrl_word_s           ctrl_reg;
    logic                 wr_tgl_reg;
    logic                 selected_reg;
    logic [WB-1:0]        wr_word_next;
    logic                 addr_pin_sync;

    // Link domain, rising edge
    logic                 rfs_prev_reg;
    logic [3:0]           rd_cnt_reg;
    logic [WB-1:0]        rd_shift_reg;
    logic                 dout_reg;
    logic                 dout_oe_reg;
    logic [WB-1:0]        result_link;

    // Core domain
    logic                 trig_sync;
    logic                 trig_prev_reg;
    logic                 trig_fall;
    logic                 trig_rise;
    logic [WB-1:0]        ctrl_core_bits;
    ctrl_word_s           ctrl_core;
    logic                 ctrl_new;
    conv_state_e          state_reg;
    logic [7:0]           cnt_reg;
    logic                 hold_reg;
    logic [WB-1:0]        result_reg;
    logic                 res_tgl_reg;
    pwr_state_s           pwr_reg;

    // ======================================================================
    // Pin synchronisers
    sync_2ff #(.WIDTH(1)) u_addr_sync (
        .i_clk   (i_serial_clk),
        .i_rstn  (i_rstn),
        .i_async (i_package_address_pin),
        .o_sync  (addr_pin_sync)
    );

    sync_2ff #(.WIDTH(1)) u_trig_sync (
        .i_clk   (i_core_clk),
        .i_rstn  (i_rstn),
        .i_async (i_conversion_trigger),
        .o_sync  (trig_sync)
    );

    // ======================================================================
    // Write path: control word in on falling serial clock edges
    assign wr_word_next = {wr_shift_reg[WB-2:0], i_serial_din};               // [RQ7]

    always_ff @(negedge i_serial_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tfs_prev_reg <= 1'b0;
        end else begin
            tfs_prev_reg <= i_transmit_frame_sync;
        end
    end

    always_ff @(negedge i_serial_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_cnt_reg   <= 4'h0;
            wr_shift_reg <= '0;
        end else if (wr_cnt_reg == 4'h0) begin
            if (tfs_prev_reg && !i_transmit_frame_sync) begin                // [RQ1]
                wr_shift_reg <= wr_word_next;
                wr_cnt_reg   <= 4'h1;
            end
        end else if (wr_cnt_reg < 4'(`ADC_WR_DATA_CLKS)) begin
            wr_shift_reg <= wr_word_next;                                     // [RQ1]
            wr_cnt_reg   <= wr_cnt_reg + 4'h1;
        end else if (wr_cnt_reg < 4'(`ADC_WR_FRAME_CLKS)) begin
            // Trailing clocks of the frame carry nothing
            wr_cnt_reg <= wr_cnt_reg + 4'h1;                                  // [RQ6]
        end else begin
            wr_cnt_reg <= 4'h0;                                               // [RQ6]
        end
    end

    // Word commits on its tenth bit, so a host that stops early still writes
    always_ff @(negedge i_serial_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_reg     <= ctrl_word_s'(`ADC_CTRL_RESET);                    // [RQ14]
            wr_tgl_reg   <= 1'b0;
            selected_reg <= 1'b0;
        end else if (wr_cnt_reg == 4'(`ADC_WR_DATA_CLKS - 1)) begin
            if (wr_word_next[`ADC_F_ADDR] == addr_pin_sync) begin             // [RQ10]
                ctrl_reg     <= ctrl_word_s'(wr_word_next);                   // [RQ6]
                wr_tgl_reg   <= ~wr_tgl_reg;
                selected_reg <= 1'b1;                                         // [RQ13]
            end else begin
                // Word belongs to the other device on the bus
                selected_reg <= 1'b0;                                         // [RQ13]
            end
        end
    end

    // ======================================================================
    // Read path: result out on rising serial clock edges
    always_ff @(posedge i_serial_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rfs_prev_reg <= 1'b0;
        end else begin
            rfs_prev_reg <= i_receive_frame_sync;
        end
    end

    // Result only refreshed between frames so a read never tears
    word_cross_rx #(.WIDTH(WB)) u_result_rx (
        .i_clk   (i_serial_clk),
        .i_rstn  (i_rstn),
        .i_tgl   (res_tgl_reg),
        .i_word  (result_reg),
        .i_allow (rd_cnt_reg == 4'h0),
        .o_word  (result_link),
        .o_new   ()
    );

    always_ff @(posedge i_serial_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_cnt_reg   <= 4'h0;
            rd_shift_reg <= '0;
            dout_reg     <= 1'b0;
            dout_oe_reg  <= 1'b0;                                             // [RQ15]
        end else if (rd_cnt_reg == 4'h0) begin
            // Clock activity ignored until the read sync rises
            if (i_receive_frame_sync && !rfs_prev_reg) begin                  // [RQ2]
                rd_cnt_reg   <= 4'h1;
                rd_shift_reg <= {result_link[WB-2:0], 1'b0};
                dout_reg     <= selected_reg && result_link[WB-1];            // [RQ4]
                dout_oe_reg  <= selected_reg;                                 // [RQ12] [RQ13]
            end
        end else if (rd_cnt_reg < 4'(`ADC_RD_DATA_CLKS)) begin
            rd_cnt_reg   <= rd_cnt_reg + 4'h1;
            rd_shift_reg <= {rd_shift_reg[WB-2:0], 1'b0};
            dout_reg     <= dout_oe_reg && rd_shift_reg[WB-1];                // [RQ4]
        end else begin
            // Eleventh rise: release the bus and rearm for the next frame
            rd_cnt_reg  <= 4'h0;                                              // [RQ3]
            dout_reg    <= 1'b0;
            dout_oe_reg <= 1'b0;                                              // [RQ5] [RQ15]
        end
    end

    assign o_serial_dout    = dout_reg;
    assign o_serial_dout_oe = dout_oe_reg;

    // ======================================================================
    // Control word into the core domain
    word_cross_rx #(.WIDTH(WB)) u_ctrl_rx (
        .i_clk   (i_core_clk),
        .i_rstn  (i_rstn),
        .i_tgl   (wr_tgl_reg),
        .i_word  (ctrl_reg),
        .i_allow (1'b1),
        .o_word  (ctrl_core_bits),
        .o_new   (ctrl_new)
    );

    assign ctrl_core = ctrl_word_s'(ctrl_core_bits);

    // ======================================================================
    // Trigger edges
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            trig_prev_reg <= 1'b0;
        end else begin
            trig_prev_reg <= trig_sync;
        end
    end

    assign trig_fall = trig_prev_reg && !trig_sync;
    assign trig_rise = !trig_prev_reg && trig_sync;

    // ======================================================================
    // Conversion sequencer
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 8'h00;
            hold_reg  <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= 8'h00;
                    if (trig_fall) begin
                        hold_reg  <= 1'b1;                                    // [RQ8]
                        state_reg <= ST_CONV;
                    end else if (ctrl_new && ctrl_core.soft_conv) begin
                        // Settling gap lets a channel change acquire first
                        state_reg <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (cnt_reg == 8'(`ADC_SOFT_DELAY_CYCLES - 1)) begin
                        cnt_reg   <= 8'h00;
                        hold_reg  <= 1'b1;
                        state_reg <= ST_CONV;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
                ST_CONV: begin
                    if (cnt_reg == 8'(`ADC_CONV_CYCLES - 1)) begin
                        cnt_reg   <= 8'h00;
                        hold_reg  <= 1'b0;
                        state_reg <= ST_DONE;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                    hold_reg  <= 1'b0;
                end
            endcase
        end
    end

    // ======================================================================
    // Result hand-off to the link domain
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            result_reg  <= '0;
            res_tgl_reg <= 1'b0;
        end else if (state_reg == ST_CONV && cnt_reg == 8'(`ADC_CONV_CYCLES - 1)) begin
            result_reg  <= i_conv_result;
            res_tgl_reg <= ~res_tgl_reg;
        end
    end

    // ======================================================================
    // Power control
    // Reset value matches the all-zero word: fully powered down
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pwr_reg <= '{power_down: 1'b1, partial: 1'b0};                    // [RQ14]
        end else if (ctrl_new && ctrl_core.pd == `ADC_PD_FULL_NOW) begin
            pwr_reg <= '{power_down: 1'b1, partial: 1'b0};
        end else if (ctrl_new && ctrl_core.pd == `ADC_PD_POWER_UP) begin
            pwr_reg <= '{power_down: 1'b0, partial: 1'b0};
        end else if (ctrl_core.pd == `ADC_PD_PARTIAL_EOC
                     || ctrl_core.pd == `ADC_PD_FULL_EOC) begin
            if (state_reg == ST_DONE && !trig_sync) begin
                // Trigger still low at end of conversion: sleep
                pwr_reg <= '{power_down: 1'b1,                                // [RQ9]
                             partial: (ctrl_core.pd == `ADC_PD_PARTIAL_EOC)};
            end else if (state_reg == ST_DONE || trig_rise) begin
                pwr_reg <= '{power_down: 1'b0, partial: 1'b0};                // [RQ9]
            end
        end
    end

    // ======================================================================
    // Outputs to the analogue core
    assign o_track_hold                = hold_reg;
    assign o_power_down                = pwr_reg.power_down;
    assign o_partial_power_down        = pwr_reg.partial;
    assign o_external_reference_select = ctrl_core.ext_ref;
    assign o_input_config              = ctrl_core.in_cfg;

endmodule : adc_serial_port

`default_nettype wire

// ---- pkg/adc_port_cfg.svh ----
// Constants for the sampling converter serial port: fields, counts, timing.
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH

// ==========================================================================
// Control word layout
`define ADC_WORD_BITS          10
`define ADC_CTRL_RESET         10'h000
`define ADC_F_ADDR             8
`define ADC_F_PD_HI            7
`define ADC_F_PD_LO            6
`define ADC_F_SOFT_CONV        1
`define ADC_F_EXT_REF          0

// ==========================================================================
// Power control codes
`define ADC_PD_FULL_NOW        2'h0
`define ADC_PD_PARTIAL_EOC     2'h1
`define ADC_PD_FULL_EOC        2'h2
`define ADC_PD_POWER_UP        2'h3

// ==========================================================================
// Serial frame counts
`define ADC_WR_DATA_CLKS       10
`define ADC_WR_FRAME_CLKS      13
`define ADC_RD_DATA_CLKS       10
`define ADC_RD_TRISTATE_CLK    11

// ==========================================================================
// Timing, core clock 100 MHz
`define ADC_CLK_PERIOD_NS      10
`define ADC_CONV_TIME_NS       2300
`define ADC_SOFT_DELAY_NS      400
`define ADC_CONV_CYCLES        (`ADC_CONV_TIME_NS / `ADC_CLK_PERIOD_NS)
`define ADC_SOFT_DELAY_CYCLES  ((`ADC_SOFT_DELAY_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)

`endif

// ---- pkg/adc_port_pkg.sv ----
// Types shared by the sampling converter serial port files.
package adc_port_pkg;

    // ======================================================================
    // Control word as shifted in, MSB first
    typedef struct packed {
        logic       spare;
        logic       addr;
        logic [1:0] pd;
        logic [3:0] in_cfg;
        logic       soft_conv;
        logic       ext_ref;
    } ctrl_word_s;

    // ======================================================================
    // Analogue power state
    typedef struct packed {
        logic power_down;
        logic partial;
    } pwr_state_s;

    // ======================================================================
    // Conversion sequencer
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_DELAY = 4'h2,
        ST_CONV  = 4'h4,
        ST_DONE  = 4'h8
    } conv_state_e;

endpackage : adc_port_pkg

// ---- rtl/sync_2ff.sv ----
// Two flip-flop level synchroniser.
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    // Data
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule : sync_2ff

`default_nettype wire

// ---- rtl/word_cross_rx.sv ----
// Receiving end of a toggle handshake that carries one stable word across.
`timescale 1ns/1ps
`default_nettype none

module word_cross_rx #(
    parameter int WIDTH = 10
) (
    // Clock and reset of the receiving domain
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    // From the sending domain
    input  wire logic             i_tgl,
    input  wire logic [WIDTH-1:0] i_word,
    // Receiver control
    input  wire logic             i_allow,
    // Captured word
    output logic      [WIDTH-1:0] o_word,
    output logic                  o_new
);

    logic             tgl_sync;
    logic             seen_reg;
    logic [WIDTH-1:0] word_reg;
    logic             new_reg;

    sync_2ff #(.WIDTH(1)) u_tgl_sync (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_async (i_tgl),
        .o_sync  (tgl_sync)
    );

    // Sender holds the word until its next toggle, so it is stable here
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            seen_reg <= 1'b0;
            word_reg <= '0;
            new_reg  <= 1'b0;
        end else begin
            new_reg <= 1'b0;
            if ((tgl_sync != seen_reg) && i_allow) begin
                seen_reg <= tgl_sync;
                word_reg <= i_word;
                new_reg  <= 1'b1;
            end
        end
    end

    assign o_word = word_reg;
    assign o_new  = new_reg;

endmodule : word_cross_rx

`default_nettype wire

// ---- sim/host_port_model.sv ----
// Host serial port model: write and read frames on the link.
`timescale 1ns/1ps
`default_nettype none

module host_port_model (
    // Link towards the device
    output logic      o_serial_clk,
    output logic      o_transmit_frame_sync,
    output logic      o_receive_frame_sync,
    output logic      o_serial_din,
    // Answer from the device
    input  wire logic i_serial_dout,
    input  wire logic i_serial_dout_oe
);
    // ====================
    // Idle state, clock stands low between frames
    initial begin
        o_serial_clk          = 1'b0;
        o_transmit_frame_sync = 1'b1;
        o_receive_frame_sync  = 1'b0;
        o_serial_din          = 1'b0;
    end

    // ====================
    // One period; din only moves mid low phase
    task automatic tick();
        #16 o_serial_clk = 1'b1;
        #32 o_serial_clk = 1'b0;
        #16;
    endtask : tick

    task automatic write_word(input logic [12:0] bits);
        #3;
        repeat (4) tick();                  // Sync high at a fall arms the frame
        o_transmit_frame_sync = 1'b0;
        for (int i = 12; i >= 0; i--) begin // Thirteen clocks per write
            o_serial_din = bits[i];         // Stable across the falling edge
            tick();
        end
        o_transmit_frame_sync = 1'b1;
        o_serial_din          = ~o_serial_din; // No stale bit on a released line
    endtask : write_word

    task automatic read_word(output logic [9:0] w, output logic [10:0] oe);
        #3;
        repeat (4) tick();                  // Clock runs before the sync rise
        o_receive_frame_sync = 1'b1;        // Sync rise doubles as bus select
        for (int i = 10; i >= 0; i--) begin
            #16 o_serial_clk = 1'b1;
            #30 oe[i] = i_serial_dout_oe;
            if (i > 0) w[i-1] = i_serial_dout_oe ? i_serial_dout : !i_serial_dout;
            #2 o_serial_clk = 1'b0;
            #16;
        end
        o_receive_frame_sync = 1'b0;
    endtask : read_word
endmodule : host_port_model
`default_nettype wire

// ---- sim/adc_serial_port_monitor.sv ----
// Concurrent checks on the serial port and conversion sequencer.
`timescale 1ns/1ps
`default_nettype none

module adc_serial_port_monitor (
    // Clocks and reset
    input wire logic       i_core_clk,
    input wire logic       i_rstn,
    input wire logic       i_serial_clk,
    // Pins
    input wire logic       i_transmit_frame_sync,
    input wire logic       i_receive_frame_sync,
    input wire logic       i_conversion_trigger,
    // Watched outputs
    input wire logic       o_serial_dout,
    input wire logic       o_serial_dout_oe,
    input wire logic       o_track_hold,
    input wire logic       o_power_down,
    input wire logic       o_external_reference_select,
    input wire logic [3:0] o_input_config
);
    // ====================
    // Helper counters
    logic [8:0] hold_cnt_reg;
    logic [3:0] idle_cnt_reg;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hold_cnt_reg <= 9'h000;
        end else begin
            hold_cnt_reg <= o_track_hold ? hold_cnt_reg + 9'h001 : 9'h000;
        end
    end

    // Saturates so long idle spells still count as idle
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            idle_cnt_reg <= 4'h0;
        end else if (o_track_hold) begin
            idle_cnt_reg <= 4'h0;
        end else if (idle_cnt_reg != 4'hF) begin
            idle_cnt_reg <= idle_cnt_reg + 4'h1;
        end
    end

    // ====================
    // Sequences
    sequence trig_fall_s;
        $fell(i_conversion_trigger) && !o_power_down && (idle_cnt_reg >= 4'h4);
    endsequence
    sequence read_burst_s;
        o_serial_dout_oe [*8] ##1 o_serial_dout_oe [*2] ##1 !o_serial_dout_oe;
    endsequence

    // ====================
    // Assertions
    AST_HOLD_START:
        assert property (@(posedge i_core_clk) disable iff (!i_rstn)
            trig_fall_s |-> ##[2:5] o_track_hold) else $error("hold late after trigger");
    AST_HOLD_LEN:
        assert property (@(posedge i_core_clk) disable iff (!i_rstn)
            $fell(o_track_hold) |-> hold_cnt_reg == 9'h0E6) else $error("hold length wrong");
    AST_HOLD_GAP:
        assert property (@(posedge i_core_clk) disable iff (!i_rstn)
            $fell(o_track_hold) |-> !o_track_hold [*2]) else $error("hold gap too short");
    AST_CFG_IN_FRAME:
        assert property (@(posedge i_core_clk) disable iff (!i_rstn)
            $changed(o_input_config) |-> !i_transmit_frame_sync) else $error("config outside write");
    AST_REF_IN_FRAME:
        assert property (@(posedge i_core_clk) disable iff (!i_rstn)
            $changed(o_external_reference_select) |-> !i_transmit_frame_sync)
            else $error("reference select outside write");
    AST_READ_SYNC_RISE:
        assert property (@(posedge i_serial_clk) disable iff (!i_rstn)
            $rose(o_serial_dout_oe) |-> $past(i_receive_frame_sync)
            && !$past(i_receive_frame_sync, 2)) else $error("drive without sync rise");
    AST_READ_LEN:
        assert property (@(posedge i_serial_clk) disable iff (!i_rstn)
            $rose(o_serial_dout_oe) |-> read_burst_s) else $error("read burst length wrong");
    AST_DOUT_IDLE:
        assert property (@(posedge i_serial_clk) disable iff (!i_rstn)
            !o_serial_dout_oe |-> !o_serial_dout) else $error("data moves while released");
endmodule : adc_serial_port_monitor

bind adc_serial_port adc_serial_port_monitor i_adc_serial_port_monitor (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_serial_clk(i_serial_clk),
    .i_transmit_frame_sync(i_transmit_frame_sync),
    .i_receive_frame_sync(i_receive_frame_sync),
    .i_conversion_trigger(i_conversion_trigger),
    .o_serial_dout(o_serial_dout), .o_serial_dout_oe(o_serial_dout_oe),
    .o_track_hold(o_track_hold), .o_power_down(o_power_down),
    .o_external_reference_select(o_external_reference_select),
    .o_input_config(o_input_config)
);
`default_nettype wire

// ---- sim/adc_serial_port_tb.sv ----
// Self-checking bench for the converter serial port.
`include "adc_port_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_serial_port_tb;
    logic                      i_core_clk, i_rstn, sclk, transmit_frame_sync, receive_frame_sync, din, dout, dout_oe;
    logic                      trig, apin, hold, pwr, part, ext, sel;
    logic [3:0]                cfg, cfg_e;
    logic [`ADC_WORD_BITS-1:0] result, w;
    logic                      ext_e, pwr_e;
    logic [31:0]               seed = 32'h07D7;
    int                        n_fail = 0, n_checks = 0, cycles = 0;

    adc_serial_port i_adc_serial_port (
        .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_serial_clk(sclk),
        .i_transmit_frame_sync(transmit_frame_sync), .i_receive_frame_sync(receive_frame_sync), .i_serial_din(din),
        .o_serial_dout(dout), .o_serial_dout_oe(dout_oe), .i_conversion_trigger(trig),
        .i_package_address_pin(apin), .i_conv_result(result), .o_track_hold(hold),
        .o_power_down(pwr), .o_partial_power_down(part),
        .o_external_reference_select(ext), .o_input_config(cfg));
    host_port_model i_host_port_model (
        .o_serial_clk(sclk), .o_transmit_frame_sync(transmit_frame_sync), .o_receive_frame_sync(receive_frame_sync),
        .o_serial_din(din), .i_serial_dout(dout), .i_serial_dout_oe(dout_oe));

    // ====================
    // Expectation helpers
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xorshift
    function automatic logic [1:0] exp_pwr(input logic [1:0] code);
        return (code == `ADC_PD_POWER_UP) ? 2'h0 : {1'b1, code == `ADC_PD_PARTIAL_EOC};
    endfunction : exp_pwr

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        $display("Checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    task automatic write(input logic a, input logic [1:0] pd, input logic s);
        seed = xorshift(seed);
        w = {seed[9], a, pd, seed[5:2], s, seed[0]};
        i_host_port_model.write_word({w, seed[12:10]}); // Tail bits are noise
    endtask : write
    task automatic read_check(input logic s, input logic data);
        logic [9:0]  rw;
        logic [10:0] oe;
        i_host_port_model.read_word(rw, oe);
        check(16'(oe), s ? 16'h07FE : 16'h0000);
        if (data) check(16'(rw), 16'(result));
    endtask : read_check
    task automatic wait_hold(input logic v);
        for (int k = 0; k < 300 && hold !== v; k++) @(negedge i_core_clk);
        check(16'(hold), 16'(v));
    endtask : wait_hold
    task automatic convert(input logic keep_low);
        @(negedge i_core_clk);
        seed   = xorshift(seed);
        result = seed[9:0];
        trig   = 1'b0;
        repeat (5) @(negedge i_core_clk);
        trig = !keep_low;
        wait_hold(1'b1);
        wait_hold(1'b0);
        repeat (6) @(negedge i_core_clk);
    endtask : convert

    // ====================
    // Clock, timeout, sequence
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            close_out();
        end
    end

    initial begin
        i_rstn = 1'b0;
        trig   = 1'b1;
        result = '0;
        apin   = seed[1];
        repeat (16) @(posedge i_core_clk);
        @(negedge i_core_clk) i_rstn = 1'b1;
        repeat (3) @(negedge i_core_clk);
        check(16'({dout_oe, hold, pwr, part, ext, cfg}), 16'h0040);
        {cfg_e, ext_e, pwr_e} = 6'h01;
        // Random address bits; last one matches
        for (int n = 0; n < 8; n++) begin
            seed = xorshift(seed);
            write((n == 7) ? apin : seed[0], `ADC_PD_POWER_UP, 1'b0);
            sel = (w[8] === apin);
            if (sel) {cfg_e, ext_e, pwr_e} = {w[5:2], w[0], 1'b0};
            check(16'({pwr, cfg, ext}), 16'({pwr_e, cfg_e, ext_e}));
            read_check(sel, 1'b0);
        end
        convert(1'b0);
        read_check(1'b1, 1'b1);
        read_check(1'b1, 1'b1);
        // Codes 1, 2, 3 (soft start) then 0; trigger low at the end for codes 1 and 2
        for (int c = 1; c < 5; c++) begin
            write(apin, 2'(c), c == 3);
            if (c == 3) wait_hold(1'b1);
            if (c == 3) wait_hold(1'b0);
            else if (c < 4) convert(1'b1);
            check(16'({pwr, part}), 16'(exp_pwr(2'(c))));
            @(negedge i_core_clk) trig = 1'b1;
            repeat (10) @(negedge i_core_clk);
        end
        close_out();
    end
endmodule : adc_serial_port_tb
`default_nettype wire
